/* File: logic/ohp_buf_if.sv */
// ohp_buf_if: valid/ready stream between port and buffer
// assumes: both ends on the core clock
interface ohp_buf_if #(parameter int unsigned W = 9);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : ohp_buf_if

/* File: logic/ohp_host_port.sv */
// ohp_host_port: 8-bit 6800-style parallel host port of a display module
// assumes: host pins already synchronous to core_clk; bytes go to the
// display core through a two-entry buffer, reads come from rd_byte
// Overview of operation
// (R1) the port joins a transfer only while chip select is low.
// (R2) direction high reads with the port driving, low writes.
// (R3) kind high marks display data, low routes the byte as a command.
// (R4) init_low low runs initialization; host keeps it high otherwise.
// (R5) the enable strobe qualifies every read or write cycle.
// (R6) bytes move over eight shared two-way bus lines.
// (R7) writes sample at the strobe's fall; reads drive only in strobe.
module ohp_host_port
   import ohp_pkg::*;
(
   // clock and reset
   input  wire logic                            core_clk,
   input  wire logic                            rstn,
   // host pins
   input  wire logic                            cs_n,
   input  wire logic                            rd_wr,
   input  wire logic                            data_cmd,
   input  wire logic                            enable,
   input  wire logic                            init_low,
   input  wire logic [ohp_pkg::OHP_DATA_W-1:0]  bus_in,
   output logic      [ohp_pkg::OHP_DATA_W-1:0]  bus_out,
   output logic                                 bus_oe,
   // core side
   output logic                                 init_busy,
   output logic                                 wr_valid,
   input  wire logic                            wr_ready,
   output logic                                 wr_is_data,
   output logic      [ohp_pkg::OHP_DATA_W-1:0]  wr_byte,
   input  wire logic [ohp_pkg::OHP_DATA_W-1:0]  rd_byte,
   output logic                                 rd_taken,
   output logic                                 wr_dropped
);
   import ohp_pkg::*;
   localparam int unsigned BW = OHP_DATA_W + 1;

   if (OHP_INIT_CYC < 1 || OHP_INIT_CYC > 16'hFFFF) begin : g_bad_init
      $error("init hold must fit the 16-bit counter");
   end

   ohp_state_t             st_reg, st_next;
   logic                   en_reg, en_next;
   logic [15:0]            ini_reg, ini_next;
   logic [OHP_DATA_W-1:0]  out_reg, out_next;
   logic                   oe_reg, oe_next;
   logic                   busy_reg, busy_next;
   logic                   rdt_reg, rdt_next;
   logic                   drop_reg, drop_next;
   logic                   ph_valid;
   logic [BW-1:0]          ph_data;
   logic                   bv;
   logic [BW-1:0]          bd;
   logic                   fall;

   ohp_buf_if #(.W(BW)) wr_if ();
   assign wr_if.valid = ph_valid;
   assign wr_if.data  = ph_data;

   ohp_skid_buf #(.W(BW), .DEPTH(OHP_BUF_DEPTH)) u_buf (
      .core_clk  (core_clk),
      .rstn      (rstn),
      .in_s      (wr_if),
      .out_valid (bv),
      .out_ready (wr_ready),
      .out_data  (bd)
   );

   // strobe fall ends a cycle [R5]
   assign fall = en_reg && !enable;

   always_comb begin
      st_next   = st_reg;
      en_next   = enable;
      ini_next  = ini_reg;
      out_next  = out_reg;
      oe_next   = 1'b0;
      busy_next = busy_reg;
      rdt_next  = 1'b0;
      drop_next = 1'b0;
      ph_valid  = 1'b0;
      ph_data   = {data_cmd, bus_in};
      case (st_reg)
         OHP_ST_INIT: begin
            busy_next = 1'b1;
            if (init_low) begin
               if (ini_reg >= 16'(OHP_INIT_CYC - 1)) begin
                  st_next   = OHP_ST_IDLE;
                  busy_next = 1'b0;
               end else begin
                  ini_next = 16'(ini_reg + 16'd1);
               end
            end else begin
               ini_next = '0;
            end
         end
         OHP_ST_IDLE: begin
            if (!cs_n && enable) begin // [R1] [R5]
               st_next = OHP_ST_STROBE;
               if (rd_wr == OHP_DIR_RD) begin // [R2]
                  out_next = rd_byte;
                  oe_next  = 1'b1; // [R6] [R7]
               end
            end
         end
         OHP_ST_STROBE: begin
            // drive only while strobe high and selected [R7]
            oe_next = (rd_wr == OHP_DIR_RD) && !cs_n && enable;
            if (fall || cs_n) begin
               st_next = OHP_ST_IDLE;
               if (fall && !cs_n && rd_wr == OHP_DIR_WR) begin // [R7]
                  ph_valid  = 1'b1; // [R3] kind bit rides with byte
                  drop_next = !wr_if.ready;
               end
               if (fall && !cs_n && rd_wr == OHP_DIR_RD) begin
                  rdt_next = 1'b1;
               end
            end
         end
         default: st_next = OHP_ST_IDLE;
      endcase
      // init overrides any transfer [R4]
      if (!init_low) begin
         st_next   = OHP_ST_INIT;
         ini_next  = '0;
         busy_next = 1'b1;
         oe_next   = 1'b0;
         ph_valid  = 1'b0;
         rdt_next  = 1'b0;
         drop_next = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st_reg   <= OHP_ST_INIT;
         en_reg   <= 1'b0;
         ini_reg  <= '0;
         out_reg  <= OHP_RD_RESET;
         oe_reg   <= 1'b0;
         busy_reg <= 1'b1;
         rdt_reg  <= 1'b0;
         drop_reg <= 1'b0;
      end else begin
         st_reg   <= st_next;
         en_reg   <= en_next;
         ini_reg  <= ini_next;
         out_reg  <= out_next;
         oe_reg   <= oe_next;
         busy_reg <= busy_next;
         rdt_reg  <= rdt_next;
         drop_reg <= drop_next;
      end
   end

   // head flops of the buffer drive the core directly, so the word
   // offered and the word popped are always the same one
   assign wr_valid   = bv;
   assign wr_is_data = bd[OHP_DATA_W];
   assign wr_byte    = bd[OHP_DATA_W-1:0];
   assign bus_out    = out_reg;
   assign bus_oe     = oe_reg;
   assign init_busy  = busy_reg;
   assign rd_taken   = rdt_reg;
   assign wr_dropped = drop_reg;

   property p_oe_needs_sel;
      @(posedge core_clk) disable iff (!rstn)
      bus_oe |-> ($past(enable) && !$past(cs_n) && $past(rd_wr));
   endproperty
   a_oe_needs_sel: assert property (p_oe_needs_sel) // [R7]
      else $error("bus driven outside a selected read strobe");

   property p_cs_gates;
      @(posedge core_clk) disable iff (!rstn)
      (cs_n && st_reg == OHP_ST_IDLE) |=> !bus_oe;
   endproperty
   a_cs_gates: assert property (p_cs_gates) // [R1]
      else $error("port active while deselected");

   property p_write_push;
      @(posedge core_clk) disable iff (!rstn)
      (st_reg == OHP_ST_STROBE && fall && !cs_n && !rd_wr && init_low)
         |-> ph_valid && ph_data[OHP_DATA_W] == data_cmd;
   endproperty
   a_write_push: assert property (p_write_push) // [R3]
      else $error("write at strobe fall not captured with kind");

   property p_init;
      @(posedge core_clk) disable iff (!rstn)
      !init_low |=> init_busy && !bus_oe;
   endproperty
   a_init: assert property (p_init) // [R4]
      else $error("init_low did not start initialization");

   property p_read_dir;
      @(posedge core_clk) disable iff (!rstn)
      (st_reg == OHP_ST_IDLE && !cs_n && enable && !rd_wr) |=> !bus_oe;
   endproperty
   a_read_dir: assert property (p_read_dir) // [R2]
      else $error("port drove the bus on a write");

   property p_no_strobe;
      @(posedge core_clk) disable iff (!rstn)
      (!enable && st_reg == OHP_ST_IDLE) |-> !ph_valid;
   endproperty
   a_no_strobe: assert property (p_no_strobe) // [R5]
      else $error("transfer without enable strobe");

   property p_read_val;
      @(posedge core_clk) disable iff (!rstn)
      (st_reg == OHP_ST_IDLE && !cs_n && enable && rd_wr && init_low)
         |=> bus_oe && bus_out == $past(rd_byte);
   endproperty
   a_read_val: assert property (p_read_val) // [R6]
      else $error("read byte not driven on bus lines");

   property p_stream_hold;
      @(posedge core_clk) disable iff (!rstn)
      (wr_valid && !wr_ready) |=> wr_valid && $stable(wr_byte)
         && $stable(wr_is_data);
   endproperty
   a_stream_hold: assert property (p_stream_hold) // [R3]
      else $error("offered byte changed before it was taken");

   property p_rd_pulse;
      @(posedge core_clk) disable iff (!rstn)
      rd_taken |=> !rd_taken;
   endproperty
   a_rd_pulse: assert property (p_rd_pulse) // [R5]
      else $error("one read strobe reported twice");
endmodule : ohp_host_port

/* File: logic/ohp_pkg.sv */
// ohp_pkg: constants and types shared by the parallel host port files
// assumes: single 40 MHz core clock, inputs synchronous to it
package ohp_pkg;
   localparam int unsigned OHP_DATA_W    = 8;
   localparam int unsigned OHP_BUF_DEPTH = 2;
   localparam int unsigned OHP_CLK_MHZ   = 40;
   // init hold after the init_low input rises, in ns
   localparam int unsigned OHP_INIT_NS   = 1000;
   localparam int unsigned OHP_INIT_CYC  =
      (OHP_INIT_NS * OHP_CLK_MHZ + 999) / 1000;
   localparam logic [7:0]  OHP_RD_RESET  = 8'h00;
   localparam logic        OHP_KIND_CMD  = 1'b0;
   localparam logic        OHP_KIND_DATA = 1'b1;
   localparam logic        OHP_DIR_WR    = 1'b0;
   localparam logic        OHP_DIR_RD    = 1'b1;
   typedef enum logic [1:0] {OHP_ST_INIT, OHP_ST_IDLE, OHP_ST_STROBE}
      ohp_state_t;
endpackage : ohp_pkg

/* File: logic/ohp_skid_buf.sv */
// ohp_skid_buf: two-entry buffer with valid/ready on both sides
// assumes: one clock, asynchronous active-low reset
module ohp_skid_buf #(
   parameter int unsigned W     = 9,
   parameter int unsigned DEPTH = 2
) (
   // clock and reset
   input  wire logic         core_clk,
   input  wire logic         rstn,
   // fill side
   ohp_buf_if.snk            in_s,
   // drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   import ohp_pkg::*;

   if (DEPTH != 2) begin : g_bad_depth
      $error("ohp_skid_buf serves exactly two entries");
   end

   logic [W-1:0] mem_reg [2];
   logic [W-1:0] mem_next [2];
   logic [1:0]   cnt_reg, cnt_next;
   logic         vld_reg, vld_next;
   logic         push, pop;

   assign in_s.ready = (cnt_reg != 2'd2);
   // valid kept in its own flop so the drain side sees a register
   assign out_valid  = vld_reg;
   assign out_data   = mem_reg[0];
   assign push       = in_s.valid && in_s.ready;
   assign pop        = out_valid && out_ready;

   always_comb begin
      mem_next = mem_reg;
      cnt_next = cnt_reg;
      if (pop) begin
         mem_next[0] = mem_reg[1];
      end
      if (push) begin
         // slot index follows the count left after a pop
         if (pop ? (cnt_reg == 2'd1) : (cnt_reg == 2'd0)) begin
            mem_next[0] = in_s.data;
         end else begin
            mem_next[1] = in_s.data;
         end
      end
      cnt_next = 2'(cnt_reg + {1'b0, push} - {1'b0, pop});
      vld_next = (cnt_next != 2'd0);
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_reg    <= 2'd0;
         vld_reg    <= 1'b0;
         mem_reg[0] <= '0;
         mem_reg[1] <= '0;
      end else begin
         cnt_reg <= cnt_next;
         vld_reg <= vld_next;
         mem_reg <= mem_next;
      end
   end

   property p_no_overfill;
      @(posedge core_clk) disable iff (!rstn)
      (cnt_reg == 2'd2 && !out_ready) |=> (cnt_reg == 2'd2);
   endproperty
   a_no_overfill: assert property (p_no_overfill)
      else $error("buffer lost an entry while stalled");
endmodule : ohp_skid_buf

/* File: tb/ohp_host_model.sv */
// ohp_host_model: behavioural 6800-style host driving the parallel port
// assumes: bench resolves the bus lines from bus_oe and host_d
module ohp_host_model (
   // clock
   input  wire logic       core_clk,
   // host pins
   output logic            cs_n,
   output logic            rd_wr,
   output logic            data_cmd,
   output logic            enable,
   output logic [7:0]      host_d,
   input  wire logic [7:0] bus,
   // read result, one-cycle pulse
   output logic            got,
   output logic [7:0]      got_byte
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      cs_n = 1'h1;
      rd_wr = 1'h0;
      data_cmd = 1'h0;
      enable = 1'h0;
      host_d = 8'h00;
      got = 1'h0;
      got_byte = 8'h00;
   end

   // sel low leaves chip select high: a strobe the port must ignore
   task automatic xfer(input logic rd, input logic kind,
                       input logic [7:0] b, input int hold,
                       input logic sel);
      @(posedge core_clk);
      cs_n <= ~sel;
      rd_wr <= rd;
      data_cmd <= kind;
      if (!rd) begin
         host_d <= b;
      end
      enable <= 1'h1;
      repeat (hold) @(posedge core_clk);
      got_byte <= bus;
      got <= rd & sel;
      enable <= 1'h0;
      // write sampled by the port here, so hold everything one edge
      @(posedge core_clk);
      got <= 1'h0;
      cs_n <= 1'h1;
      // released lines must not keep showing the old byte
      host_d <= ~host_d;
   endtask : xfer
endmodule : ohp_host_model

/* File: tb/tb_top.sv */
// tb_top: self-checking bench for the parallel host port
// assumes: host model drives the pins, bench plays the display core
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ohp_pkg::*;

   logic       core_clk, rstn, init_low, wr_ready, stall;
   logic       cs_n, rd_wr, data_cmd, enable, bus_oe, init_busy;
   logic       wr_valid, wr_is_data, rd_taken, wr_dropped, got;
   logic [7:0] bus_out, host_d, bus_lines, wr_byte, rd_byte, got_byte;
   logic [8:0] q[$];
   logic [7:0] rq[$];
   logic [31:0] seed, r;
   int         mismatches, n_compared, n_drop, n_taken, nreads, n_cyc;

   assign bus_lines = (bus_oe == 1'h1) ? bus_out : host_d;

   ohp_host_model host (.core_clk(core_clk), .cs_n(cs_n), .rd_wr(rd_wr),
      .data_cmd(data_cmd), .enable(enable), .host_d(host_d),
      .bus(bus_lines), .got(got), .got_byte(got_byte));

   ohp_host_port dut (.core_clk(core_clk), .rstn(rstn), .cs_n(cs_n),
      .rd_wr(rd_wr), .data_cmd(data_cmd), .enable(enable),
      .init_low(init_low), .bus_in(bus_lines), .bus_out(bus_out),
      .bus_oe(bus_oe), .init_busy(init_busy), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_is_data(wr_is_data), .wr_byte(wr_byte),
      .rd_byte(rd_byte), .rd_taken(rd_taken), .wr_dropped(wr_dropped));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task automatic chk(input string name, input logic [8:0] seen,
                      input logic [8:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize

   task automatic wait_init();
      for (int i = 0; i < 100 && init_busy !== 1'h0; i++) begin
         @(negedge core_clk);
      end
      chk("init_busy", 9'(init_busy), 9'h000);
   endtask : wait_init

   task automatic drain();
      for (int i = 0; i < 400 && q.size() != 0; i++) begin
         @(negedge core_clk);
      end
      chk("left", 9'(q.size()), 9'h000);
   endtask : drain

   initial begin
      core_clk = 1'h0;
      forever #12.5 core_clk = ~core_clk;
   end

   // core side stalls at random unless told to hold off completely;
   // never two stalled cycles running, so spaced writes never overfill
   always @(posedge core_clk) begin
      wr_ready <= stall ? 1'h0
                        : ((wr_ready !== 1'h1) || ((xs() & 32'h1) != 32'h0));
   end

   always @(posedge core_clk) begin
      n_cyc++;
      if (rstn === 1'h1 && wr_valid === 1'h1 && wr_ready === 1'h1) begin
         if (q.size() == 0) begin
            chk("wr_extra", 9'h001, 9'h000);
         end else begin
            chk("wr_byte", {wr_is_data, wr_byte}, q.pop_front());
         end
      end
      if (got === 1'h1) begin
         chk("rd_byte", {1'h0, got_byte}, {1'h0, rq.pop_front()});
      end
      if (wr_dropped === 1'h1) begin
         n_drop++;
      end
      if (rd_taken === 1'h1) begin
         n_taken++;
      end
      if (n_cyc == 20000) begin
         mismatches++;
         summarize();
      end
   end

   initial begin
      seed = 32'h00017D27;
      rstn = 1'h0;
      init_low = 1'h1;
      stall = 1'h0;
      rd_byte = 8'h00;
      repeat (20) @(posedge core_clk);
      rstn <= 1'h1;
      host.xfer(1'h0, 1'h1, 8'h5A, 1, 1'h1);
      @(negedge core_clk);
      chk("init_busy", 9'(init_busy), 9'h001);
      wait_init();
      host.xfer(1'h0, 1'h0, 8'h33, 1, 1'h0);
      host.xfer(1'h1, 1'h0, 8'h00, 2, 1'h0);
      @(negedge core_clk);
      chk("rd_taken", 9'(n_taken), 9'h000);
      for (int i = 0; i < 40; i++) begin
         r = xs();
         if (r[0]) begin
            rd_byte <= r[15:8];
            rq.push_back(r[15:8]);
            nreads++;
            host.xfer(1'h1, r[1], 8'h00, 2 + int'(r[3:2]), 1'h1);
         end else begin
            q.push_back({r[1], r[15:8]});
            host.xfer(1'h0, r[1], r[15:8], 1 + int'(r[3:2]), 1'h1);
         end
      end
      drain();
      @(negedge core_clk);
      chk("bus_oe", 9'(bus_oe), 9'h000);
      chk("rd_taken", 9'(n_taken), 9'(nreads));
      // full buffer under stall, then init must keep its contents
      stall = 1'h1;
      repeat (3) @(negedge core_clk);
      q.push_back(9'h1C3);
      q.push_back(9'h03C);
      host.xfer(1'h0, 1'h1, 8'hC3, 1, 1'h1);
      host.xfer(1'h0, 1'h0, 8'h3C, 2, 1'h1);
      host.xfer(1'h0, 1'h1, 8'hEE, 1, 1'h1);
      repeat (4) @(negedge core_clk);
      chk("wr_dropped", 9'(n_drop), 9'h001);
      @(posedge core_clk);
      init_low <= 1'h0;
      repeat (3) @(negedge core_clk);
      chk("init_busy", 9'(init_busy), 9'h001);
      @(posedge core_clk);
      init_low <= 1'h1;
      wait_init();
      stall = 1'h0;
      drain();
      summarize();
   end
endmodule : tb_top
